// File: common/adh_pkg.sv
// Package: constants, types and state codes for the axis demand and homing block
package adh_pkg;
   localparam int NUM_AXES = 4;
   localparam int AXIS_W = 2;
   localparam int POS_W = 32;
   localparam int DEM_W = 16;
   localparam int SPD_W = 16;
   localparam int STAT_W = 16;
   localparam int SCALE_W = 8;
   localparam int INPUTS = 64;
   localparam int SEL_W = 7;
   // Selector value -1 in seven bits: datum input disabled
   localparam logic [SEL_W-1:0] SEL_DISABLED = 7'h7F;
   // Axis status bits cleared by the error-clearing sequences: 1,2,3,8,11
   localparam logic [STAT_W-1:0] CLR_MASK = 16'h090E;
   localparam logic signed [DEM_W-1:0] DEM_ZERO = 16'h0000;
   // 12-bit code range: -2048 is +10 V, 2047 is -10 V
   localparam logic signed [DEM_W-1:0] DAC12_MIN = 16'hF800;
   localparam logic signed [DEM_W-1:0] DAC12_MAX = 16'h07FF;
   // 16-bit code range: 32767 is +10 V, -32768 is -10 V
   localparam logic signed [DEM_W-1:0] DAC16_MIN = 16'h8000;
   localparam logic signed [DEM_W-1:0] DAC16_MAX = 16'h7FFF;
   localparam logic [2:0] SEQ_CLR_ALL = 3'h0;
   localparam logic [2:0] SEQ_CLR_BASE = 3'h7;

   typedef enum logic [1:0] {
      ADH_OUT_DIG = 2'h0,
      ADH_OUT_A12 = 2'h1,
      ADH_OUT_A16 = 2'h2,
      ADH_OUT_POS = 2'h3
   } adh_out_e;

   typedef enum logic [5:0] {
      ADH_IDLE = 6'h01,
      ADH_FAST = 6'h02,
      ADH_REL = 6'h04,
      ADH_ZSRCH = 6'h08,
      ADH_ZERO = 6'h10,
      ADH_DONE = 6'h20
   } adh_state_e;

   typedef struct packed {
      logic run;
      logic fwd;
      logic signed [SPD_W-1:0] speed;
   } adh_move_s;
endpackage : adh_pkg

// File: logic/adh_axis_demand_homing.sv
// Axis demand output stage and homing sequencer
// Summary of operation
// RL1 - Servo off, enabled: written demand drives output
// RL2 - Writes always accepted; output zero when disabled
// RL3 - 12-bit output codes -2048..2047 span +10..-10V
// RL4 - 16-bit output codes 32767..-32768 span +10..-10V
// RL5 - Readback: loop output if servo on, else written
// RL6 - Loop output multiplied by signed scale factor
// RL7 - No scaling on position based axes
// RL8 - Sequence 0 clears error bits on all axes
// RL9 - Sequence 1: creep forward to Z, zero position
// RL10 - Sequence 2: creep reverse to Z, zero position
// RL11 - Sequence 3: fast forward to switch, creep off
// RL12 - Sequence 4: fast reverse to switch, creep off
// RL13 - Sequence 5: forward, back off, reverse to Z
// RL14 - Sequence 6: reverse, back off, forward to Z
// RL15 - Sequence 7 clears error bits base axis only
// RL16 - Datum switch active low, fail safe
// RL17 - Slow phases creep speed, fast programmed speed
// RL18 - Selector -1 disables, else input 0 to 63
// RL19 - After zeroing, stop and report idle
module adh_axis_demand_homing (
   input wire logic clk,
   input wire logic reset,
   input wire logic servo_on,
   input wire logic axis_enable,
   input wire logic drive_watchdog,
   input wire adh_pkg::adh_out_e axis_type_code,
   input wire logic dac_wr,
   input wire logic signed [adh_pkg::DEM_W-1:0] dac_wr_data,
   input wire logic signed [adh_pkg::DEM_W-1:0] loop_out,
   input wire logic signed [adh_pkg::SCALE_W-1:0] dac_scale,
   input wire logic signed [adh_pkg::DEM_W-1:0] pos_demand,
   input wire logic datum_start,
   input wire logic [2:0] datum_seq,
   input wire logic [adh_pkg::AXIS_W-1:0] base_axis,
   input wire logic [adh_pkg::SEL_W-1:0] datum_in_sel,
   input wire logic [adh_pkg::INPUTS-1:0] dig_inputs,
   input wire logic z_marker,
   input wire logic signed [adh_pkg::POS_W-1:0] enc_pos,
   input wire logic signed [adh_pkg::SPD_W-1:0] creep_speed,
   input wire logic signed [adh_pkg::SPD_W-1:0] prog_speed,
   input wire logic [adh_pkg::NUM_AXES*adh_pkg::STAT_W-1:0] status_set,
   output logic signed [adh_pkg::DEM_W-1:0] dac_out,
   output logic signed [adh_pkg::DEM_W-1:0] dac_readback,
   output adh_pkg::adh_move_s move,
   output logic signed [adh_pkg::POS_W-1:0] meas_pos,
   output logic signed [adh_pkg::POS_W-1:0] dem_pos,
   output logic homing_busy,
   output logic [adh_pkg::NUM_AXES*adh_pkg::STAT_W-1:0] axis_status_word
);
   localparam int PW = adh_pkg::POS_W;
   localparam int DW = adh_pkg::DEM_W;
   localparam int SW = adh_pkg::STAT_W;

   function automatic logic signed [DW-1:0] sat(input logic signed [DW+adh_pkg::SCALE_W-1:0] v,
                                               input logic signed [DW-1:0] lo,
                                               input logic signed [DW-1:0] hi);
      logic signed [DW+adh_pkg::SCALE_W-1:0] lo_x;
      logic signed [DW+adh_pkg::SCALE_W-1:0] hi_x;
      lo_x = {{adh_pkg::SCALE_W{lo[DW-1]}}, lo};
      hi_x = {{adh_pkg::SCALE_W{hi[DW-1]}}, hi};
      if (v < lo_x) begin
         sat = lo;
      end else if (v > hi_x) begin
         sat = hi;
      end else begin
         sat = v[DW-1:0];
      end
   endfunction : sat

   logic signed [DW-1:0] user_dac_r;
   logic signed [DW-1:0] dac_out_r;
   logic signed [DW-1:0] dac_readback_r;
   logic signed [DW-1:0] dac_out_nxt;
   logic signed [DW-1:0] dac_readback_nxt;
   adh_pkg::adh_state_e state_r;
   adh_pkg::adh_state_e state_nxt;
   logic fwd_r;
   logic use_z_r;
   logic fast_fwd_r;
   logic sw_seen_r;
   logic signed [PW-1:0] meas_pos_r;
   logic signed [PW-1:0] dem_pos_r;
   logic signed [PW-1:0] enc_last_r;
   logic busy_r;
   logic [adh_pkg::NUM_AXES*SW-1:0] status_r;
   typedef logic [adh_pkg::AXIS_W-1:0] adh_axis_t;
   adh_pkg::adh_move_s move_r;
   adh_pkg::adh_move_s move_nxt;

   // Selected input read low counts as the switch being active
   wire sel_valid = (datum_in_sel != adh_pkg::SEL_DISABLED) && !datum_in_sel[6]; // [RL18]
   wire datum_active = sel_valid && !dig_inputs[datum_in_sel[5:0]]; // [RL16]
   wire out_allowed = drive_watchdog && axis_enable; // [RL2]
   wire is_pos_axis = (axis_type_code == adh_pkg::ADH_OUT_POS);
   wire signed [DW+adh_pkg::SCALE_W-1:0] scaled = loop_out * dac_scale; // [RL6]
   // Position axes bypass the scale since their demand is not the loop output
   wire signed [DW+adh_pkg::SCALE_W-1:0] loop_term = is_pos_axis ?
      {{adh_pkg::SCALE_W{pos_demand[DW-1]}}, pos_demand} : scaled; // [RL7]
   wire signed [DW+adh_pkg::SCALE_W-1:0] user_term =
      {{adh_pkg::SCALE_W{user_dac_r[DW-1]}}, user_dac_r};
   wire signed [DW+adh_pkg::SCALE_W-1:0] raw_dem = servo_on ? loop_term : user_term; // [RL1]
   wire signed [DW-1:0] lim_lo = (axis_type_code == adh_pkg::ADH_OUT_A12) ?
      adh_pkg::DAC12_MIN : adh_pkg::DAC16_MIN; // [RL3] [RL4]
   wire signed [DW-1:0] lim_hi = (axis_type_code == adh_pkg::ADH_OUT_A12) ?
      adh_pkg::DAC12_MAX : adh_pkg::DAC16_MAX; // [RL3] [RL4]
   wire signed [DW-1:0] dem_sat = sat(raw_dem, lim_lo, lim_hi);
   wire signed [DW-1:0] user_sat = sat(user_term, lim_lo, lim_hi);
   wire z_hit = use_z_r && z_marker;

   always_comb begin
      dac_out_nxt = out_allowed ? dem_sat : adh_pkg::DEM_ZERO; // [RL2]
      dac_readback_nxt = servo_on ? dem_sat : user_sat; // [RL5]
   end

   always_comb begin
      state_nxt = state_r;
      move_nxt = move_r;
      case (state_r)
         adh_pkg::ADH_IDLE: begin
            move_nxt.run = 1'b0;
            if (datum_start && datum_seq != adh_pkg::SEQ_CLR_ALL &&
                datum_seq != adh_pkg::SEQ_CLR_BASE) begin
               move_nxt.run = 1'b1;
               if (datum_seq == 3'h1 || datum_seq == 3'h2) begin
                  move_nxt.fwd = (datum_seq == 3'h1); // [RL9] [RL10]
                  move_nxt.speed = creep_speed; // [RL17]
                  state_nxt = adh_pkg::ADH_ZSRCH;
               end else begin
                  move_nxt.fwd = datum_seq[0]; // [RL11] [RL12] [RL13] [RL14]
                  move_nxt.speed = prog_speed; // [RL17]
                  state_nxt = adh_pkg::ADH_FAST;
               end
            end
         end
         adh_pkg::ADH_FAST: begin
            if (datum_active) begin
               move_nxt.fwd = !move_r.fwd; // [RL11] [RL12]
               move_nxt.speed = creep_speed; // [RL17]
               state_nxt = adh_pkg::ADH_REL;
            end
         end
         adh_pkg::ADH_REL: begin
            if (!datum_active) begin
               state_nxt = use_z_r ? adh_pkg::ADH_ZSRCH : adh_pkg::ADH_ZERO; // [RL13] [RL14]
            end
         end
         adh_pkg::ADH_ZSRCH: begin
            if (z_marker) begin
               state_nxt = adh_pkg::ADH_ZERO; // [RL9] [RL10]
            end
         end
         adh_pkg::ADH_ZERO: begin
            move_nxt.run = 1'b0; // [RL19]
            state_nxt = adh_pkg::ADH_DONE;
         end
         adh_pkg::ADH_DONE: begin
            state_nxt = adh_pkg::ADH_IDLE; // [RL19]
         end
         default: begin
            move_nxt.run = 1'b0;
            state_nxt = adh_pkg::ADH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         user_dac_r <= adh_pkg::DEM_ZERO;
         dac_out_r <= adh_pkg::DEM_ZERO;
         dac_readback_r <= adh_pkg::DEM_ZERO;
      end else begin
         if (dac_wr) begin
            user_dac_r <= dac_wr_data; // [RL2]
         end
         dac_out_r <= dac_out_nxt;
         dac_readback_r <= dac_readback_nxt;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= adh_pkg::ADH_IDLE;
         move_r <= '0;
         use_z_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         move_r <= move_nxt;
         busy_r <= (state_nxt != adh_pkg::ADH_IDLE);
         if (state_r == adh_pkg::ADH_IDLE && datum_start) begin
            use_z_r <= (datum_seq == 3'h1) || (datum_seq == 3'h2) ||
                       (datum_seq == 3'h5) || (datum_seq == 3'h6);
         end
      end
   end

   // Zeroing keeps the following error: demand moves by the same offset
   // Tracks encoder deltas so a zeroed position is not overwritten later
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meas_pos_r <= '0;
         dem_pos_r <= '0;
         enc_last_r <= '0;
      end else begin
         enc_last_r <= enc_pos;
         if (state_r == adh_pkg::ADH_ZERO) begin
            meas_pos_r <= '0; // [RL9] [RL11]
            dem_pos_r <= dem_pos_r - meas_pos_r; // [RL10] [RL12]
         end else begin
            meas_pos_r <= meas_pos_r + (enc_pos - enc_last_r);
            dem_pos_r <= dem_pos_r + (enc_pos - enc_last_r);
         end
      end
   end

   // Set wins over clear so a fresh fault is never lost
   genvar ax;
   for (ax = 0; ax < adh_pkg::NUM_AXES; ax++) begin : g_stat
      wire clr_this = state_r == adh_pkg::ADH_IDLE && datum_start &&
         (datum_seq == adh_pkg::SEQ_CLR_ALL || // [RL8]
          (datum_seq == adh_pkg::SEQ_CLR_BASE && base_axis == adh_axis_t'(ax))); // [RL15]
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            status_r[ax*SW +: SW] <= '0;
         end else if (clr_this) begin
            status_r[ax*SW +: SW] <= (status_r[ax*SW +: SW] & ~adh_pkg::CLR_MASK) |
                                     status_set[ax*SW +: SW];
         end else begin
            status_r[ax*SW +: SW] <= status_r[ax*SW +: SW] | status_set[ax*SW +: SW];
         end
      end
   end
   assign dac_out = dac_out_r;
   assign dac_readback = dac_readback_r;
   assign move = move_r;
   assign meas_pos = meas_pos_r;
   assign dem_pos = dem_pos_r;
   assign homing_busy = busy_r;
   assign axis_status_word = status_r;

   AST_OUT_ZERO: assert property (@(posedge clk) disable iff (reset)
      !$past(out_allowed) |-> dac_out == adh_pkg::DEM_ZERO) // [RL2]
      else $error("Demand not zero while disabled");
   AST_USER_DEM: assert property (@(posedge clk) disable iff (reset)
      $past(out_allowed) && !$past(servo_on) |-> dac_out == $past(user_sat)) // [RL1]
      else $error("Written demand not driven");
   AST_RB: assert property (@(posedge clk) disable iff (reset)
      !$past(servo_on) |-> dac_readback == $past(user_sat)) // [RL5]
      else $error("Readback not user value");
   AST_A12: assert property (@(posedge clk) disable iff (reset)
      $past(axis_type_code) == adh_pkg::ADH_OUT_A12 |->
      dac_out >= adh_pkg::DAC12_MIN && dac_out <= adh_pkg::DAC12_MAX) // [RL3]
      else $error("12-bit demand out of range");
   AST_FAST_SPD: assert property (@(posedge clk) disable iff (reset)
      state_r == adh_pkg::ADH_FAST |-> move_r.speed == $past(prog_speed)) // [RL17]
      else $error("Fast phase speed wrong");
   AST_ZERO: assert property (@(posedge clk) disable iff (reset)
      state_r == adh_pkg::ADH_ZERO |=> meas_pos_r == '0 ##1 state_r == adh_pkg::ADH_IDLE)
      // [RL19]
      else $error("Zeroing did not end idle");
   AST_FE_KEPT: assert property (@(posedge clk) disable iff (reset)
      state_r == adh_pkg::ADH_ZERO |=>
      dem_pos_r - meas_pos_r == $past(dem_pos_r) - $past(meas_pos_r)) // [RL9]
      else $error("Following error changed at zeroing");
   AST_CLR0: assert property (@(posedge clk) disable iff (reset)
      state_r == adh_pkg::ADH_IDLE && datum_start && datum_seq == adh_pkg::SEQ_CLR_ALL &&
      status_set == '0 |=> (status_r[SW-1:0] & adh_pkg::CLR_MASK) == '0) // [RL8]
      else $error("Error bits not cleared");
   AST_REL_DIR: assert property (@(posedge clk) disable iff (reset)
      state_r == adh_pkg::ADH_FAST && datum_active |=> move_r.fwd != $past(move_r.fwd))
      // [RL11]
      else $error("No reversal at switch");
endmodule : adh_axis_demand_homing

// File: verification/adh_drive_model.sv
// Behavioural drive, encoder and datum switch seen by the homing sequencer
module adh_drive_model (
   input wire logic clk,
   input wire logic reset,
   input wire adh_pkg::adh_move_s move,
   output logic signed [31:0] enc_pos,
   output logic z_marker,
   output logic datum_sw_n
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         enc_pos <= 32'h0000_0000;
      end else if (move.run) begin
         enc_pos <= move.fwd ? enc_pos + move.speed : enc_pos - move.speed;
      end
   end
   // Cam 200..260 pulls the input low; a broken wire reads as active
   assign datum_sw_n = !(enc_pos >= 200 && enc_pos <= 260);
   // Index windows wider than a creep step so none is skipped
   assign z_marker = (enc_pos >= 150 && enc_pos <= 153) || (enc_pos >= 300 && enc_pos <= 303);
endmodule : adh_drive_model

// File: verification/adh_axis_demand_homing_tb_top.sv
// Self-checking bench for the axis demand and homing block
module adh_axis_demand_homing_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, reset, servo_on, axis_enable, drive_watchdog, dac_wr, datum_start;
   logic z_marker, datum_sw_n, homing_busy;
   adh_pkg::adh_out_e axis_type_code;
   logic signed [15:0] dac_wr_data, loop_out, pos_demand, creep_speed, prog_speed;
   logic signed [15:0] dac_out, dac_readback;
   logic signed [7:0] dac_scale;
   logic [2:0] datum_seq;
   logic [1:0] base_axis;
   logic [6:0] datum_in_sel;
   logic [63:0] dig_inputs, status_set, axis_status_word;
   logic signed [31:0] enc_pos, meas_pos, dem_pos;
   adh_pkg::adh_move_s move;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   assign dig_inputs = {{58{1'b1}}, datum_sw_n, 5'h1F};
   adh_axis_demand_homing i_dut (.clk(clk), .reset(reset), .servo_on(servo_on),
      .axis_enable(axis_enable), .drive_watchdog(drive_watchdog),
      .axis_type_code(axis_type_code), .dac_wr(dac_wr), .dac_wr_data(dac_wr_data),
      .loop_out(loop_out), .dac_scale(dac_scale), .pos_demand(pos_demand),
      .datum_start(datum_start), .datum_seq(datum_seq), .base_axis(base_axis),
      .datum_in_sel(datum_in_sel), .dig_inputs(dig_inputs), .z_marker(z_marker),
      .enc_pos(enc_pos), .creep_speed(creep_speed), .prog_speed(prog_speed),
      .status_set(status_set), .dac_out(dac_out), .dac_readback(dac_readback),
      .move(move), .meas_pos(meas_pos), .dem_pos(dem_pos), .homing_busy(homing_busy),
      .axis_status_word(axis_status_word));
   adh_drive_model i_drive (.clk(clk), .reset(reset), .move(move), .enc_pos(enc_pos),
      .z_marker(z_marker), .datum_sw_n(datum_sw_n));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check
   task automatic settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic wr(input logic [15:0] d);
      @(posedge clk);
      dac_wr <= 1'b1;
      dac_wr_data <= d;
      @(posedge clk);
      dac_wr <= 1'b0;
      settle();
   endtask : wr
   task automatic start(input logic [2:0] s);
      @(posedge clk);
      datum_seq <= s;
      datum_start <= 1'b1;
      @(posedge clk);
      datum_start <= 1'b0;
   endtask : start
   task automatic test_demand;
      wr(16'h0400);
      check({dac_out, dac_readback}, 32'h0400_0400, "forced demand");
      axis_type_code <= adh_pkg::ADH_OUT_A12;
      wr(16'h7FFF);
      check({dac_out}, 16'h07FF, "12-bit top");
      wr(16'h8000);
      check({dac_out}, 16'hF800, "12-bit bottom");
      drive_watchdog <= 1'b0;
      wr(16'h0123);
      check({dac_out}, 16'h0000, "watchdog off");
      drive_watchdog <= 1'b1;
      axis_type_code <= adh_pkg::ADH_OUT_A16;
      settle();
      check({dac_out}, 16'h0123, "write kept");
      wr(16'h7FFF);
      check({dac_out}, 16'h7FFF, "16-bit top");
      $display("test demand done");
   endtask : test_demand
   task automatic test_servo;
      servo_on <= 1'b1;
      settle();
      check({dac_out, dac_readback}, 32'hFED4_FED4, "scaled loop");
      axis_type_code <= adh_pkg::ADH_OUT_POS;
      settle();
      check({dac_out}, 16'h1234, "position axis unscaled");
      $display("test servo done");
   endtask : test_servo
   task automatic test_status;
      @(posedge clk);
      status_set <= {4{16'hFFFF}};
      @(posedge clk);
      status_set <= 64'h0;
      start(3'h0);
      settle();
      check(axis_status_word, {4{16'hF6F1}}, "clear all");
      @(posedge clk);
      status_set <= {4{16'hFFFF}};
      base_axis <= 2'h2;
      @(posedge clk);
      status_set <= 64'h0;
      start(3'h7);
      settle();
      check(axis_status_word, 64'hFFFF_F6F1_FFFF_FFFF, "clear base");
      check({homing_busy, meas_pos}, 33'h0, "no position change");
      $display("test status done");
   endtask : test_status
   task automatic test_home;
      logic [2:0] sq [6] = '{3'h3, 3'h1, 3'h6, 3'h4, 3'h2, 3'h5};
      logic fw [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      logic [15:0] chg;
      int i, k;
      for (i = 0; i < 6; i++) begin
         start(sq[i]);
         @(negedge clk);
         check({move.run, move.fwd}, {1'b1, fw[i]}, "direction");
         check(move.speed, (sq[i] > 3'h2) ? prog_speed : creep_speed, "speed");
         chg = creep_speed;
         for (k = 0; k < 2000 && homing_busy !== 1'b0; k++) begin
            if (move.run === 1'b1 && move.fwd !== fw[i]) begin
               chg = move.speed;
            end
            @(negedge clk);
         end
         check(chg, creep_speed, "back-off speed");
         check({move.run, homing_busy}, 2'b00, "stopped idle");
         check(meas_pos >= -8 && meas_pos <= 8, 1'b1, "zeroed");
      end
      $display("test homing done");
   endtask : test_home
   initial begin
      reset = 1'b1;
      servo_on = 1'b0;
      axis_enable = 1'b1;
      drive_watchdog = 1'b1;
      axis_type_code = adh_pkg::ADH_OUT_A16;
      dac_wr = 1'b0;
      dac_wr_data = 16'h0000;
      loop_out = 16'h0064;
      dac_scale = 8'hFD;
      pos_demand = 16'h1234;
      datum_start = 1'b0;
      datum_seq = 3'h0;
      base_axis = 2'h0;
      datum_in_sel = 7'h05;
      creep_speed = 16'h0002;
      prog_speed = 16'h0010;
      status_set = 64'h0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      test_demand();
      test_servo();
      test_status();
      test_home();
      print_verdict();
   end
endmodule : adh_axis_demand_homing_tb_top
